// ===== rtl/edma_top.sv
`include "edma_defines.svh"
`default_nettype none
module edma_top
  import edma_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        pb_en,
  input  wire logic        pb_wr,
  input  wire logic [7:0]  pb_addr,
  input  wire logic [31:0] pb_wdata,
  output logic      [31:0] pb_rdata,
  input  wire logic [2:0]  smbus_target_xfer_req,
  input  wire logic [2:0]  smbus_host_xfer_req,
  input  wire logic        serial_flash_rx_req,
  input  wire logic        serial_flash_tx_req,
  input  wire logic [2:0]  smbus_target_xfer_term,
  input  wire logic [2:0]  smbus_host_xfer_term,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hready,
  input  wire logic        hresp,
  output logic      [15:0] sram_addr,
  output logic             sram_re,
  output logic             sram_we,
  output logic      [7:0]  sram_wdata,
  input  wire logic [7:0]  sram_rdata,
  output logic      [7:0]  dma_done_int
);

  localparam int NCH = `EDMA_NUM_CH;

  edma_ch_e    st_reg    [NCH];
  edma_ch_e    st_next   [NCH];
  logic        run_reg   [NCH];
  logic        run_next  [NCH];
  logic        dir_reg   [NCH];
  logic        dir_next  [NCH];
  logic [2:0]  dev_reg   [NCH];
  logic [2:0]  dev_next  [NCH];
  logic        done_reg  [NCH];
  logic        done_next [NCH];
  logic [1:0]  stat_reg  [NCH];
  logic [1:0]  stat_next [NCH];
  logic [15:0] end_reg   [NCH];
  logic [15:0] end_next  [NCH];
  logic [15:0] cnt_reg   [NCH];
  logic [15:0] cnt_next  [NCH];
  logic [31:0] badr_reg  [NCH];
  logic [31:0] badr_next [NCH];
  logic [7:0]  act_reg   [NCH];
  logic [7:0]  act_next  [NCH];
  logic [7:0]  req_sel;
  logic [7:0]  term_sel;

  edma_eng_e   eng_reg;
  edma_eng_e   eng_next;
  edma_idx_t   cur_reg;
  edma_idx_t   cur_next;
  logic [7:0]  byte_reg;
  logic [7:0]  byte_next;
  logic        xfer_done;
  logic        xfer_err;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        wr_hit;
  edma_idx_t   acc_ch;
  logic [4:0]  acc_ofs;

  edma_arb_if arb_bus ();

  edma_arb u_arb (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .arb     (arb_bus.arb)
  );

  // Maps device select and direction onto one of the source lines.
  function automatic logic sel_line(input logic [2:0] dev, input logic dir,
                                    input logic [2:0] tgt, input logic [2:0] hst,
                                    input logic frx, input logic ftx);
    logic res;
    res = 1'b0;
    if (dev == 3'h6)
      res = dir ? ftx : frx;
    else if (dev != 3'h7)
      res = dev[0] ? hst[dev[2:1]] : tgt[dev[2:1]];
    return res;
  endfunction

  // ==========================================================================
  // Source selection
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      req_sel[i]  = sel_line(dev_reg[i], dir_reg[i], smbus_target_xfer_req,
                             smbus_host_xfer_req, serial_flash_rx_req, serial_flash_tx_req);
      term_sel[i] = sel_line(dev_reg[i], dir_reg[i], smbus_target_xfer_term,
                             smbus_host_xfer_term, 1'b0, 1'b0);
      arb_bus.ready[i] = (st_reg[i] == CH_RUN) && run_reg[i] && req_sel[i]
                         && (cnt_reg[i] != end_reg[i]) && !term_sel[i];
    end
  end

  // ==========================================================================
  // Shared byte engine
  always_comb
  begin
    eng_next      = eng_reg;
    cur_next      = cur_reg;
    byte_next     = byte_reg;
    xfer_done     = 1'b0;
    xfer_err      = 1'b0;
    arb_bus.take  = (eng_reg == E_IDLE) && arb_bus.grant_valid;
    case (eng_reg)
      E_IDLE:
        if (arb_bus.take)
        begin
          cur_next = arb_bus.grant_idx;
          eng_next = dir_reg[arb_bus.grant_idx] ? E_SRAM_R : E_AHB_A;
        end
      E_SRAM_R:
        eng_next = E_SRAM_D;
      E_SRAM_D:
      begin
        byte_next = sram_rdata;
        eng_next  = E_AHB_A;
      end
      E_AHB_A:
        if (hready)
          eng_next = E_AHB_D;
      E_AHB_D:
        if (hready)
        begin
          if (hresp)
          begin
            xfer_done = 1'b1;
            xfer_err  = 1'b1;
            eng_next  = E_IDLE;
          end
          else if (!dir_reg[cur_reg])
          begin
            byte_next = hrdata[{badr_reg[cur_reg][1:0], 3'b000} +: 8];
            eng_next  = E_SRAM_W;
          end
          else
          begin
            xfer_done = 1'b1;
            eng_next  = E_IDLE;
          end
        end
      E_SRAM_W:
      begin
        xfer_done = 1'b1;
        eng_next  = E_IDLE;
      end
      default:
        eng_next = E_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eng_reg  <= E_IDLE;
      cur_reg  <= 3'h0;
      byte_reg <= 8'h00;
    end
    else
    begin
      eng_reg  <= eng_next;
      cur_reg  <= cur_next;
      byte_reg <= byte_next;
    end
  end

  assign haddr      = badr_reg[cur_reg];
  assign htrans     = (eng_reg == E_AHB_A) ? `EDMA_HTRANS_NONSEQ : `EDMA_HTRANS_IDLE;
  assign hwrite     = dir_reg[cur_reg];
  assign hsize      = `EDMA_HSIZE_BYTE;
  assign hwdata     = {4{byte_reg}};
  assign sram_addr  = cnt_reg[cur_reg];
  assign sram_re    = (eng_reg == E_SRAM_R);
  assign sram_we    = (eng_reg == E_SRAM_W);
  assign sram_wdata = byte_reg;

  // ==========================================================================
  // Channel registers and state machines
  assign acc_ch  = pb_addr[7:5];
  assign acc_ofs = pb_addr[4:0];
  assign wr_hit  = pb_en && pb_wr;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      st_next[i]   = st_reg[i];
      run_next[i]  = run_reg[i];
      dir_next[i]  = dir_reg[i];
      dev_next[i]  = dev_reg[i];
      done_next[i] = done_reg[i];
      stat_next[i] = stat_reg[i];
      end_next[i]  = end_reg[i];
      cnt_next[i]  = cnt_reg[i];
      badr_next[i] = badr_reg[i];
      act_next[i]  = act_reg[i];
      if (wr_hit && acc_ch == 3'(i))
      begin
        if (acc_ofs == `EDMA_OFS_CTRL)
        begin
          run_next[i] = pb_wdata[`EDMA_CTRL_RUN];
          if (!run_reg[i])
          begin
            dir_next[i] = pb_wdata[`EDMA_CTRL_DIR];
            dev_next[i] = pb_wdata[`EDMA_CTRL_DEV +: 3];
          end
        end
        else if (run_reg[i])
          run_next[i] = run_reg[i];
        else if (acc_ofs == `EDMA_OFS_END)
          end_next[i] = pb_wdata[15:0];
        else if (acc_ofs == `EDMA_OFS_START)
          cnt_next[i] = pb_wdata[15:0];
        else if (acc_ofs == `EDMA_OFS_BUSADDR)
          badr_next[i] = pb_wdata;
        else if (acc_ofs == `EDMA_OFS_ACT)
          act_next[i] = pb_wdata[7:0];
      end
      case (st_reg[i])
        CH_IDLE:
          if (run_next[i] && !run_reg[i])
          begin
            st_next[i]   = CH_RUN;
            done_next[i] = 1'b0;
          end
        CH_RUN:
          if (arb_bus.take && arb_bus.grant_idx == 3'(i))
            st_next[i] = CH_XFER;
          else if (!run_next[i])
            st_next[i] = CH_IDLE;
          else if (cnt_reg[i] == end_reg[i])
          begin
            st_next[i]   = CH_IDLE;
            done_next[i] = 1'b1;
            stat_next[i] = `EDMA_ST_END;
          end
          else if (term_sel[i])
          begin
            st_next[i]   = CH_IDLE;
            done_next[i] = 1'b1;
            stat_next[i] = `EDMA_ST_TERM;
          end
        CH_XFER:
          if (xfer_done && cur_reg == 3'(i))
          begin
            if (!xfer_err)
              cnt_next[i] = cnt_reg[i] + 16'h0001;
            if (!run_next[i])
              st_next[i] = CH_IDLE;
            else if (!xfer_err && cnt_next[i] == end_reg[i])
            begin
              st_next[i]   = CH_IDLE;
              done_next[i] = 1'b1;
              stat_next[i] = `EDMA_ST_END;
            end
            else if (term_sel[i])
            begin
              st_next[i]   = CH_IDLE;
              done_next[i] = 1'b1;
              stat_next[i] = `EDMA_ST_TERM;
            end
            else if (xfer_err)
            begin
              st_next[i]   = CH_IDLE;
              done_next[i] = 1'b1;
              stat_next[i] = `EDMA_ST_BUSERR;
            end
            else
              st_next[i] = CH_RUN;
          end
        default:
          st_next[i] = CH_IDLE;
      endcase
      if (!run_next[i])
      begin
        done_next[i] = 1'b0;
        stat_next[i] = `EDMA_ST_STOPPED;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        st_reg[i]   <= CH_IDLE;
        run_reg[i]  <= 1'b0;
        dir_reg[i]  <= 1'b0;
        dev_reg[i]  <= 3'h0;
        done_reg[i] <= 1'b0;
        stat_reg[i] <= `EDMA_ST_STOPPED;
        end_reg[i]  <= `EDMA_RST_OFS;
        cnt_reg[i]  <= `EDMA_RST_OFS;
        badr_reg[i] <= `EDMA_RST_ADDR;
        act_reg[i]  <= `EDMA_RST_ACT;
      end
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        st_reg[i]   <= st_next[i];
        run_reg[i]  <= run_next[i];
        dir_reg[i]  <= dir_next[i];
        dev_reg[i]  <= dev_next[i];
        done_reg[i] <= done_next[i];
        stat_reg[i] <= stat_next[i];
        end_reg[i]  <= end_next[i];
        cnt_reg[i]  <= cnt_next[i];
        badr_reg[i] <= badr_next[i];
        act_reg[i]  <= act_next[i];
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      dma_done_int[i] = done_reg[i];
  end

  // ==========================================================================
  // Register read port
  always_comb
  begin
    rdata_next = rdata_reg;
    if (pb_en && !pb_wr)
    begin
      rdata_next = 32'h0000_0000;
      if (acc_ofs == `EDMA_OFS_CTRL)
      begin
        rdata_next[`EDMA_CTRL_RUN]       = run_reg[acc_ch];
        rdata_next[`EDMA_CTRL_REQ]       = run_reg[acc_ch] && req_sel[acc_ch];
        rdata_next[`EDMA_CTRL_DONE]      = done_reg[acc_ch];
        rdata_next[`EDMA_CTRL_STAT +: 2] = stat_reg[acc_ch];
        rdata_next[`EDMA_CTRL_BUSY]      = (st_reg[acc_ch] != CH_IDLE);
        rdata_next[`EDMA_CTRL_DIR]       = dir_reg[acc_ch];
        rdata_next[`EDMA_CTRL_DEV +: 3]  = dev_reg[acc_ch];
      end
      else if (acc_ofs == `EDMA_OFS_END)
        rdata_next[15:0] = end_reg[acc_ch];
      else if (acc_ofs == `EDMA_OFS_START)
        rdata_next[15:0] = cnt_reg[acc_ch];
      else if (acc_ofs == `EDMA_OFS_BUSADDR)
        rdata_next = badr_reg[acc_ch];
      else if (acc_ofs == `EDMA_OFS_ACT)
        rdata_next[7:0] = act_reg[acc_ch];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  assign pb_rdata = rdata_reg;

  // ==========================================================================
  // Checks
  chk_go_enters_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_hit && acc_ch == 3'h0 && acc_ofs == `EDMA_OFS_CTRL && pb_wdata[0]
      && st_reg[0] == CH_IDLE && !run_reg[0]) |=> st_reg[0] == CH_RUN)
    else $error("go did not start channel");
  chk_one_owner: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (eng_reg != E_IDLE) |-> st_reg[cur_reg] == CH_XFER) else $error("engine owner lost");
  chk_inc_on_ok: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (xfer_done && !xfer_err) |=> cnt_reg[$past(cur_reg)] == $past(cnt_reg[cur_reg]) + 16'h0001)
    else $error("counter not advanced");
  chk_hold_on_err: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (xfer_done && xfer_err) |=> st_reg[$past(cur_reg)] == CH_IDLE
      && cnt_reg[$past(cur_reg)] == $past(cnt_reg[cur_reg])) else $error("bus error mishandled");
  chk_end_stops: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_reg[0] == CH_RUN && run_next[0] && cnt_reg[0] == end_reg[0])
      |=> st_reg[0] == CH_IDLE && done_reg[0] && stat_reg[0] == `EDMA_ST_END)
    else $error("end match did not stop");
  chk_term_stops: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_reg[0] == CH_RUN && run_next[0] && cnt_reg[0] != end_reg[0] && term_sel[0])
      |=> stat_reg[0] == `EDMA_ST_TERM ##1 st_reg[0] == CH_IDLE || !run_reg[0])
    else $error("termination ignored");
  chk_done_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !run_reg[0] |-> !dma_done_int[0] && stat_reg[0] == `EDMA_ST_STOPPED)
    else $error("done set while stopped");
  chk_ahb_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (htrans == `EDMA_HTRANS_NONSEQ) |-> hsize == `EDMA_HSIZE_BYTE
      && hwrite == dir_reg[cur_reg]) else $error("bad bus transfer");
  chk_sram_order: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sram_we |-> $past(eng_reg, 2) == E_AHB_A || $past(eng_reg, 2) == E_AHB_D)
    else $error("sram write without bus read");

endmodule
`default_nettype wire

// ===== rtl/edma_defines.svh
// Contract
// - Eight selectable sources; the flash selections have their termination tied to zero.
// - Direction 0 copies device receive buffer to SRAM; 1 copies SRAM to device.
// - Start offset loads a 16-bit counter advancing by one; it addresses SRAM.
// - End offset is one past last byte; finish when the counter equals it.
// - Equal start and end offsets move no bytes.
// - End below start makes the counter wrap from ffff to zero.
// - A full 16-bit address is always driven to the SRAM port.
// - Writing go as 1 moves the channel from idle to run; the code does so only when go was 0 before the write.
// - In run with request asserted, issue one byte-wide bus transfer per direction.
// - After a good transfer increment the counter, compare, else return to run.
// - Terminate to idle on counter equal end or termination input asserted.
// - On bus error suppress increment, go idle, record bus-error status.
// - Device select and direction choose request and termination; 7 is reserved.
// - All channels share one SRAM port and one bus master port.
// - Ready channels served by arrival; simultaneous arrivals lowest number first.
// - Continuously ready channels are served in rotating round-robin order.
// - Channel register window sits at base plus 0x20 times channel number.
// - Control: go 0, request 1, done 2, status 4:3, busy 5, dir 8, device above.
// - Status 00 go cleared, 01 end, 10 termination, 11 bus error; lowest wins.
// - Done reads 0 while go is 0, becomes 1 on return to idle, drives interrupt.
// - Clearing go halts, but a transfer in progress completes first.
// - Busy reads 1 outside idle and 0 in idle.
`ifndef EDMA_DEFINES_SVH
`define EDMA_DEFINES_SVH

`define EDMA_NUM_CH        8
`define EDMA_OFS_CTRL      5'h00
`define EDMA_OFS_END       5'h04
`define EDMA_OFS_START     5'h08
`define EDMA_OFS_BUSADDR   5'h0c
`define EDMA_OFS_ACT       5'h10
`define EDMA_CTRL_RUN      0
`define EDMA_CTRL_REQ      1
`define EDMA_CTRL_DONE     2
`define EDMA_CTRL_STAT     3
`define EDMA_CTRL_BUSY     5
`define EDMA_CTRL_DIR      8
`define EDMA_CTRL_DEV      9
`define EDMA_ST_STOPPED    2'h0
`define EDMA_ST_END        2'h1
`define EDMA_ST_TERM       2'h2
`define EDMA_ST_BUSERR     2'h3
`define EDMA_RST_OFS       16'h0000
`define EDMA_RST_ADDR      32'h0000_0000
`define EDMA_RST_ACT       8'h00
`define EDMA_HTRANS_IDLE   2'h0
`define EDMA_HTRANS_NONSEQ 2'h2
`define EDMA_HSIZE_BYTE    3'h0

`endif

// ===== rtl/edma_pkg.sv
`default_nettype none
package edma_pkg;
  typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_XFER} edma_ch_e;
  typedef enum logic [2:0] {E_IDLE, E_SRAM_R, E_SRAM_D, E_AHB_A, E_AHB_D, E_SRAM_W} edma_eng_e;
  typedef logic [2:0] edma_idx_t;
endpackage
`default_nettype wire

// ===== rtl/edma_arb_if.sv
`default_nettype none
interface edma_arb_if;
  logic [7:0] ready;
  logic       take;
  logic       grant_valid;
  logic [2:0] grant_idx;
  modport arb (input ready, input take, output grant_valid, output grant_idx);
  modport eng (output ready, output take, input grant_valid, input grant_idx);
endinterface
`default_nettype wire

// ===== rtl/edma_arb.sv
`default_nettype none
module edma_arb
  import edma_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  edma_arb_if.arb   arb
);

  logic [7:0] prev_reg;
  logic [7:0] prev_next;
  logic [2:0] ptr_reg;
  logic [2:0] ptr_next;
  logic [7:0] waiting;
  logic [2:0] pick_old;
  logic [2:0] pick_new;

  // Searches the mask upward from the start index, wrapping round.
  function automatic logic [2:0] pick(input logic [7:0] mask, input logic [2:0] start);
    logic [2:0] res;
    logic [2:0] k;
    res = start;
    for (int j = 7; j >= 0; j--)
    begin
      k = start + 3'(j);
      if (mask[k])
        res = k;
    end
    return res;
  endfunction

  // ==========================================================================
  // Grant selection
  always_comb
  begin
    waiting         = arb.ready & prev_reg;
    pick_old        = pick(waiting, ptr_reg);
    pick_new        = pick(arb.ready, 3'h0);
    arb.grant_valid = |arb.ready;
    arb.grant_idx   = (|waiting) ? pick_old : pick_new;
    prev_next       = arb.ready;
    ptr_next        = arb.take ? arb.grant_idx + 3'h1 : ptr_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_reg <= 8'h00;
      ptr_reg  <= 3'h0;
    end
    else
    begin
      prev_reg <= prev_next;
      ptr_reg  <= ptr_next;
    end
  end

  chk_grant_is_ready: assert property (@(posedge sys_clk) disable iff (!rst_b)
    arb.grant_valid |-> arb.ready[arb.grant_idx]) else $error("grant to a channel not ready");
  chk_fresh_lowest: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (arb.ready != 8'h00 && (arb.ready & prev_reg) == 8'h00)
      |-> (arb.ready & ((8'h01 << arb.grant_idx) - 8'h01)) == 8'h00)
    else $error("fresh arrivals not served lowest first");

endmodule
`default_nettype wire

// ===== tb/edma_far_model.sv
`default_nettype none
module edma_far_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        err_en,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hready,
  output logic             hresp,
  input  wire logic [15:0] sram_addr,
  input  wire logic        sram_re,
  input  wire logic        sram_we,
  input  wire logic [7:0]  sram_wdata,
  output logic      [7:0]  sram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Byte slave with rotating wait states, and the local SRAM.
  logic [7:0] mem [0:255];
  logic [7:0] wlog [$];
  logic       dphase;
  logic       dwr;
  logic [7:0] rd_cnt;
  logic [1:0] wait_cnt;
  logic [1:0] xcnt;
  logic [31:0] last_haddr;
  initial sram_rdata = 8'h00;
  assign hready = !dphase || wait_cnt == 2'h0;
  assign hresp  = dphase && err_en;
  // Read data outside a read data phase is inverted so stale bytes never match.
  assign hrdata = {4{(dphase && !dwr) ? rd_cnt ^ 8'ha5 : ~(rd_cnt ^ 8'ha5)}};
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      dphase <= 1'b0;
      rd_cnt <= 8'h00;
      xcnt   <= 2'h0;
    end
    else if (dphase && hready)
    begin
      dphase <= 1'b0;
      if (!hresp && dwr)
        wlog.push_back(hwdata[7:0]);
      if (!hresp && !dwr)
        rd_cnt <= rd_cnt + 8'h01;
    end
    else if (!dphase && htrans == 2'h2)
    begin
      dphase   <= 1'b1;
      dwr      <= hwrite;
      last_haddr <= haddr;
      wait_cnt <= xcnt;
      xcnt     <= xcnt + 2'h1;
    end
    else if (dphase)
      wait_cnt <= wait_cnt - 2'h1;
  always @(posedge sys_clk)
  begin
    if (sram_we)
      mem[sram_addr[7:0]] <= sram_wdata;
    sram_rdata <= sram_re ? mem[sram_addr[7:0]] : ~sram_rdata;
  end
endmodule
`default_nettype wire

// ===== tb/test_eight_channel_byte_dma.sv
`default_nettype none
module test_eight_channel_byte_dma;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pb_en = 1'b0;
  logic        pb_wr = 1'b0;
  logic [7:0]  pb_addr = 8'h00;
  logic [31:0] pb_wdata = 32'h0;
  logic [31:0] pb_rdata, haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite, hready, hresp, sram_re, sram_we;
  logic [15:0] sram_addr, s;
  logic [7:0]  sram_wdata, sram_rdata, dma_done_int;
  logic [7:0]  req = 8'h00;
  logic [5:0]  term = 6'h00;
  logic        err_en = 1'b0;
  int          n_fail = 0;
  int          comparisons = 0;
  int          nrd = 0;
  int          i;
  int          seed = 32'h09b7039e;
  always #10 sys_clk = ~sys_clk;
  edma_top dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .pb_en(pb_en), .pb_wr(pb_wr), .pb_addr(pb_addr),
    .pb_wdata(pb_wdata), .pb_rdata(pb_rdata),
    .smbus_target_xfer_req({req[4], req[2], req[0]}),
    .smbus_host_xfer_req({req[5], req[3], req[1]}),
    .serial_flash_rx_req(req[6]), .serial_flash_tx_req(req[7]),
    .smbus_target_xfer_term({term[4], term[2], term[0]}),
    .smbus_host_xfer_term({term[5], term[3], term[1]}),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hready(hready), .hresp(hresp), .sram_addr(sram_addr),
    .sram_re(sram_re), .sram_we(sram_we), .sram_wdata(sram_wdata),
    .sram_rdata(sram_rdata), .dma_done_int(dma_done_int));
  edma_far_model far (
    .sys_clk(sys_clk), .rst_b(rst_b), .err_en(err_en), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp),
    .sram_addr(sram_addr), .sram_re(sram_re), .sram_we(sram_we),
    .sram_wdata(sram_wdata), .sram_rdata(sram_rdata));
  // ==========================================================
  // Register access, comparison and transfer tasks.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic [2:0] ch, input logic [4:0] ofs, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    pb_en = 1'b1;
    pb_wr = wr;
    pb_addr = {ch, ofs};
    pb_wdata = wd;
    @(posedge sys_clk);
    #1;
    pb_en = 1'b0;
    rd = pb_rdata;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_idle(input logic [2:0] ch, output logic [31:0] rd);
    int k;
    rd = 32'h20;
    for (k = 0; k < 300 && rd[5] === 1'b1; k++)
      acc(ch, 5'h00, 1'b0, 32'h0, rd);
  endtask
  // Mode 0 moves bytes, mode 1 ends by termination, mode 2 by a bus error.
  task automatic xfer(input logic [2:0] ch, input logic [2:0] dev, input logic dir,
                      input logic [15:0] s0, input logic [15:0] e0, input logic [1:0] mode);
    logic [31:0] rr;
    logic [15:0] n;
    int          wb;
    int          k;
    n = (mode == 2'h0) ? e0 - s0 : 16'h0000;
    wb = far.wlog.size();
    for (k = 0; k < n; k++)
      far.mem[8'(s0 + k)] = 8'($random(seed));
    acc(ch, 5'h00, 1'b1, 32'h0, rr);
    acc(ch, 5'h04, 1'b1, {16'h0, e0}, rr);
    acc(ch, 5'h08, 1'b1, {16'h0, s0}, rr);
    acc(ch, 5'h0c, 1'b1, 32'h00f0_1840 + dev, rr);
    if (mode == 2'h1)
      term[dev] = 1'b1;
    else
      req[(dev == 3'h6) ? 3'(6 + dir) : dev] = 1'b1;
    err_en = (mode == 2'h2);
    acc(ch, 5'h00, 1'b1, {20'h0, dev, dir, 7'h00, 1'b1}, rr);
    wait_idle(ch, rr);
    req = 8'h00;
    term = 6'h00;
    err_en = 1'b0;
    chk("status", {1'b0, (mode == 2'h0) ? 2'h1 : mode + 2'h1, 1'b1}, rr[5:2]);
    chk("done_int", 32'h1, dma_done_int[ch]);
    acc(ch, 5'h08, 1'b0, 32'h0, rr);
    chk("counter", 16'(s0 + n), rr);
    chk("bus_writes", wb + (dir ? n : 0), far.wlog.size());
    if (n != 0)
    begin
      chk("haddr", 32'h00f0_1840 + dev, far.last_haddr);
      chk("hwrite", dir, far.dwr);
    end
    for (k = 0; k < n; k++)
      if (dir)
        chk("bus_wdata", far.mem[8'(s0 + k)], far.wlog[wb + k]);
      else
        chk("sram_byte", 8'(nrd + k) ^ 8'ha5, far.mem[8'(s0 + k)]);
    if (!dir)
      nrd += n;
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    acc(3'h5, 5'h00, 1'b0, 32'h0, r);
    chk("ctrl_reset", 32'h0, r);
    acc(3'h5, 5'h00, 1'b1, 32'hffff_fffe, r);
    acc(3'h5, 5'h00, 1'b0, 32'h0, r);
    chk("ctrl_rw", 32'h0000_0f00, r);
    acc(3'h4, 5'h0c, 1'b1, 32'hdead_beef, r);
    acc(3'h5, 5'h0c, 1'b1, 32'h0000_1234, r);
    acc(3'h5, 5'h10, 1'b1, 32'h0000_01a5, r);
    acc(3'h4, 5'h0c, 1'b0, 32'h0, r);
    chk("bus_addr", 32'hdead_beef, r);
    acc(3'h5, 5'h10, 1'b0, 32'h0, r);
    chk("activate", 32'h0000_00a5, r);
    acc(3'h5, 5'h14, 1'b0, 32'h0, r);
    chk("unmapped", 32'h0, r);
    xfer(3'h0, 3'h0, 1'b0, 16'hfffe, 16'h0001, 2'h0);
    xfer(3'h0, 3'h1, 1'b1, 16'h0040, 16'h0040, 2'h0);
    for (i = 0; i < 14; i++)
    begin
      s = 16'($random(seed));
      xfer(i[2:0], 3'(i % 7), i >= 7, s, s + 16'(1 + i % 4), 2'h0);
    end
    chk("hsize", 32'h0, hsize);
    xfer(3'h0, 3'h2, 1'b0, 16'h0010, 16'h0020, 2'h1);
    xfer(3'h4, 3'h3, 1'b0, 16'h0010, 16'h0020, 2'h2);
    xfer(3'h6, 3'h5, 1'b1, 16'h0010, 16'h0020, 2'h2);
    for (i = 0; i < 2; i++)
    begin
      acc(i[2:0], 5'h00, 1'b1, 32'h0, r);
      acc(i[2:0], 5'h04, 1'b1, 32'h22 + 16 * i, r);
      acc(i[2:0], 5'h08, 1'b1, 32'h20 + 16 * i, r);
      acc(i[2:0], 5'h00, 1'b1, 32'h1, r);
    end
    req[0] = 1'b1;
    wait_idle(3'h0, r);
    wait_idle(3'h1, r);
    req = 8'h00;
    for (i = 0; i < 4; i++)
    begin
      s = 16'(32 + 16 * (i % 2) + i / 2);
      chk("rr_byte", 8'(nrd + i) ^ 8'ha5, far.mem[s[7:0]]);
    end
    nrd += 4;
    req = 8'hff;
    acc(3'h7, 5'h00, 1'b1, 32'h0, r);
    acc(3'h7, 5'h04, 1'b1, 32'h1, r);
    acc(3'h7, 5'h08, 1'b1, 32'h0, r);
    acc(3'h7, 5'h00, 1'b1, 32'h0000_0e01, r);
    acc(3'h7, 5'h00, 1'b0, 32'h0, r);
    chk("reserved_dev", 32'h21, r[5:0]);
    acc(3'h7, 5'h00, 1'b1, 32'h0, r);
    req = 8'h00;
    // Go is cleared while the first byte is on the bus; that byte must still land.
    acc(3'h2, 5'h00, 1'b1, 32'h0, r);
    acc(3'h2, 5'h04, 1'b1, 32'h0068, r);
    acc(3'h2, 5'h08, 1'b1, 32'h0060, r);
    req[4] = 1'b1;
    acc(3'h2, 5'h00, 1'b1, 32'h0000_0801, r);
    acc(3'h2, 5'h00, 1'b1, 32'h0000_0800, r);
    wait_idle(3'h2, r);
    req = 8'h00;
    chk("run_cleared", 32'h0000_0800, r);
    chk("done_int_clr", 32'h0, dma_done_int[2]);
    acc(3'h2, 5'h08, 1'b0, 32'h0, r);
    chk("halt_counter", 32'h0000_0061, r);
    chk("halt_byte", 8'(nrd) ^ 8'ha5, far.mem[8'h60]);
    summarize();
  end
endmodule
`default_nettype wire
